// ---- verification/host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_model
	import capture_pkg::*;
(
	input  wire logic                             clk,
	input  wire logic                             rstn,
	input  wire logic                             stall,
	input  wire logic [capture_pkg::SAMPLE_W-1:0] stream_data,
	input  wire logic                             stream_valid,
	output logic                                  stream_ready,
	output int                                    taken,
	output int                                    gaps
);
	logic [SAMPLE_W-1:0] prev;
	// gap count assumes a decimation of one, so words step by two
	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stream_ready <= 1'b0;
			taken <= 0;
			gaps <= 0;
			prev <= '0;
		end
		else
		begin
			// a stalling host drops ready so the fifo overflows
			stream_ready <= !stall;
			if (stream_valid && stream_ready)
			begin
				if (taken > 0 && stream_data - prev !== 24'h000002)
					gaps <= gaps + 1;
				prev <= stream_data;
				taken <= taken + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import capture_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, arm = 1'b0, sample_valid = 1'b0;
	logic dig_in = 1'b0, soft_event = 1'b0, gated = 1'b0, stall = 1'b0;
	logic start_falling = 1'b0, trig_falling = 1'b0, stream_mode = 1'b0;
	logic [SAMPLE_W-1:0] sample = '0, threshold = '0, stream_data;
	logic [SAMPLE_W-1:0] mem_data, last_data;
	logic [ADDR_W:0]     pre_count = '0, post_count = '0;
	logic [7:0]          decim = 8'h01;
	source_t             start_src = SRC_DIGITAL, trig_src = SRC_DIGITAL;
	logic mem_we, pre_short, done, config_err, stream_valid, stream_ready;
	logic [ADDR_W-1:0]   mem_addr, trig_addr, last_addr;
	logic [1:0]          phase;
	int fails = 0, checked = 0, writes = 0, taken, gaps;

	phased_capture_sequencer u_dut (.clk, .rstn, .arm, .sample,
		.sample_valid, .dig_in, .soft_event, .start_src, .trig_src,
		.start_falling, .trig_falling, .gated, .threshold, .pre_count,
		.post_count, .stream_mode, .decim, .stream_ready, .mem_we,
		.mem_addr, .mem_data, .trig_addr, .pre_short, .done,
		.config_err, .phase, .stream_data, .stream_valid);
	host_model u_host (.clk, .rstn, .stall, .stream_data, .stream_valid,
		.stream_ready, .taken, .gaps);

	always #50 clk = ~clk;
	always @(negedge clk)
		sample <= sample + 24'h000001;
	// every write must follow the previous one, wrapping at the end
	always @(posedge clk)
		if (mem_we === 1'b1)
		begin
			if (writes > 0)
			begin
				check(mem_addr, 10'(last_addr + 10'h001));
				check(mem_data, 24'(last_data + 24'h000001));
			end
			last_addr = mem_addr;
			last_data = mem_data;
			writes++;
		end

	// ****************
	// shared tasks
	// ****************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_phase(input logic [1:0] p);
		for (int i = 0; i < 3000 && phase !== p; i++)
			@(negedge clk);
		if (phase !== p)
		begin
			fails++;
			$display("MISMATCH at %0t: phase wait timed out", $time);
			close_out;
		end
	endtask
	task automatic setup(input source_t s, input source_t t, input logic f,
		input logic g, input logic [ADDR_W:0] pr, input logic [ADDR_W:0] po);
		arm = 1'b0;
		wait_phase(ST_IDLE);
		start_src = s;
		trig_src = t;
		start_falling = f;
		trig_falling = !f;
		gated = g;
		pre_count = pr;
		post_count = po;
		dig_in = f;
		cyc(2);
		writes = 0;
		arm = 1'b1;
		cyc(2);
	endtask
	task automatic pulse;
		soft_event = 1'b1;
		cyc(1);
		soft_event = 1'b0;
		cyc(1);
	endtask
	task automatic finish_check;
		int w;
		wait_phase(ST_DONE);
		check(done, 1'b1);
		cyc(3);
		w = writes;
		check(last_addr, 10'(trig_addr + post_count[9:0] - 10'h001));
		cyc(10);
		check(writes, w);
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic edge_digital(input logic f);
		setup(SRC_DIGITAL, SRC_DIGITAL, f, 1'b0, 11'h1f4, 11'h028);
		check(phase, ST_IDLE);
		dig_in = !f;
		wait_phase(ST_PRE);
		cyc(20);
		check(phase, ST_PRE);
		dig_in = f;
		wait_phase(ST_POST);
		check(pre_short, 1'b1);
		finish_check;
	endtask
	task automatic software_same;
		setup(SRC_SOFTWARE, SRC_SOFTWARE, 1'b0, 1'b0, 11'h010, 11'h020);
		pulse;
		wait_phase(ST_PRE);
		cyc(30);
		check(phase, ST_PRE);
		pulse;
		wait_phase(ST_POST);
		check(pre_short, 1'b0);
		finish_check;
	endtask
	task automatic analog_trig;
		setup(SRC_SOFTWARE, SRC_ANALOG, 1'b0, 1'b0, 11'h010, 11'h010);
		threshold = sample + 24'h000064;
		pulse;
		wait_phase(ST_PRE);
		cyc(50);
		check(phase, ST_PRE);
		wait_phase(ST_POST);
		finish_check;
	endtask
	task automatic config_refuse;
		setup(SRC_DIGITAL, SRC_DIGITAL, 1'b0, 1'b0, 11'h200, 11'h201);
		check(config_err, 1'b1);
		dig_in = 1'b1;
		cyc(10);
		check(phase, ST_IDLE);
		dig_in = 1'b0;
		post_count = 11'h200;
		cyc(2);
		check(config_err, 1'b0);
		dig_in = 1'b1;
		wait_phase(ST_PRE);
		dig_in = 1'b0;
		finish_check;
	endtask
	task automatic gated_level;
		setup(SRC_DIGITAL, SRC_DIGITAL, 1'b0, 1'b1, 11'h010, 11'h010);
		dig_in = 1'b1;
		wait_phase(ST_PRE);
		cyc(30);
		check(phase, ST_PRE);
		dig_in = 1'b0;
		wait_phase(ST_POST);
		finish_check;
	endtask
	task automatic stream_wrap;
		int t;
		stream_mode = 1'b1;
		setup(SRC_SOFTWARE, SRC_DIGITAL, 1'b0, 1'b0, 11'h010, 11'h010);
		pulse;
		wait_phase(ST_PRE);
		dig_in = 1'b1;
		cyc(3);
		dig_in = 1'b0;
		cyc(1100);
		check(phase, ST_PRE);
		check(writes > 1024, 1'b1);
		check(taken > 400, 1'b1);
		check(gaps, 0);
		stall = 1'b1;
		cyc(50);
		t = taken;
		stall = 1'b0;
		cyc(20);
		check(taken > t, 1'b1);
		pulse;
		wait_phase(ST_POST);
		finish_check;
		stream_mode = 1'b0;
	endtask

	initial
	begin
		cyc(10);
		rstn = 1'b1;
		sample_valid = 1'b1;
		edge_digital(1'b0);
		edge_digital(1'b1);
		software_same;
		analog_trig;
		config_refuse;
		gated_level;
		stream_wrap;
		close_out;
	end
endmodule
`default_nettype wire

// ---- verilog/capture_pkg.sv ----
package capture_pkg;
	localparam int SAMPLE_W    = 24;
	localparam int ADDR_W      = 10;
	localparam int MEM_DEPTH   = 1024;
	localparam int FIFO_W      = 24;
	localparam int FIFO_DEPTH  = 4;
	localparam int DECIM_W     = 8;

	// event source selection
	typedef enum logic [1:0]
	{
		SRC_DIGITAL  = 2'b00,
		SRC_ANALOG   = 2'b01,
		SRC_SOFTWARE = 2'b10
	} source_t;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_PRE  = 2'b01,
		ST_POST = 2'b10,
		ST_DONE = 2'b11
	} phase_t;

	localparam logic [ADDR_W:0]    COUNT_RESET = 11'h000;
	localparam logic [ADDR_W-1:0]  ADDR_RESET  = 10'h000;
	localparam logic [DECIM_W-1:0] DECIM_RESET = 8'h00;
endpackage

// ---- verilog/phased_capture_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module phased_capture_sequencer
	import capture_pkg::*;
(
	input  wire logic                                clk,
	input  wire logic                                rstn,
	input  wire logic                                arm,
	input  wire logic [capture_pkg::SAMPLE_W-1:0]    sample,
	input  wire logic                                sample_valid,
	input  wire logic                                dig_in,
	input  wire logic                                soft_event,
	input  wire capture_pkg::source_t                start_src,
	input  wire capture_pkg::source_t                trig_src,
	input  wire logic                                start_falling,
	input  wire logic                                trig_falling,
	input  wire logic                                gated,
	input  wire logic [capture_pkg::SAMPLE_W-1:0]    threshold,
	input  wire logic [capture_pkg::ADDR_W:0]        pre_count,
	input  wire logic [capture_pkg::ADDR_W:0]        post_count,
	input  wire logic                                stream_mode,
	input  wire logic [capture_pkg::DECIM_W-1:0]     decim,
	input  wire logic                                stream_ready,
	output logic                                     mem_we,
	output logic      [capture_pkg::ADDR_W-1:0]      mem_addr,
	output logic      [capture_pkg::SAMPLE_W-1:0]    mem_data,
	output logic      [capture_pkg::ADDR_W-1:0]      trig_addr,
	output logic                                     pre_short,
	output logic                                     done,
	output logic                                     config_err,
	output logic      [1:0]                          phase,
	output logic      [capture_pkg::SAMPLE_W-1:0]    stream_data,
	output logic                                     stream_valid
);
	import capture_pkg::*;

	// ****************************************************************
	// event detection
	// ****************************************************************
	logic dig_prev;
	logic ana_prev;
	logic ana_above;
	logic start_hit;
	logic trig_hit;
	logic start_level;
	logic trig_level;

	assign ana_above = sample_valid && (sample >= threshold);

	// active level of the selected source, for gates and edges alike
	function automatic logic pick_level(source_t src, logic falling,
		logic d, logic a, logic s);
		unique case (src)
			SRC_DIGITAL:  return d ^ falling;
			SRC_ANALOG:   return a;
			SRC_SOFTWARE: return s;
			default:      return 1'b0;
		endcase
	endfunction

	// edge: active now, not one cycle earlier; software keeps no history
	assign start_hit   = start_level && !pick_level(start_src, start_falling,
		dig_prev, ana_prev, 1'b0);
	// in streaming mode without gating only soft_event can move the capture to post
	assign trig_hit    = stream_mode ? soft_event :
		trig_level && !pick_level(trig_src, trig_falling, dig_prev,
		ana_prev, 1'b0);
	assign start_level = pick_level(start_src, start_falling, dig_in,
		ana_above, soft_event);
	assign trig_level  = pick_level(trig_src, trig_falling, dig_in,
		ana_above, soft_event);

	// ****************************************************************
	// phase sequencer and memory addressing
	// ****************************************************************
	phase_t              state;
	phase_t              next_state;
	logic [ADDR_W-1:0]   addr;
	logic [ADDR_W-1:0]   next_addr;
	logic [ADDR_W:0]     pre_cnt;
	logic [ADDR_W:0]     next_pre_cnt;
	logic [ADDR_W:0]     post_cnt;
	logic [ADDR_W:0]     next_post_cnt;
	logic [ADDR_W-1:0]   next_trig_addr;
	logic                fit_ok;
	logic                go_post;
	logic                writing;

	// total must fit the memory; otherwise the capture will not start
	assign fit_ok = ({1'b0, pre_count} + {1'b0, post_count})
		<= (ADDR_W+2)'(MEM_DEPTH);
	// gated mode: post starts once the start level is released
	assign go_post = gated ? !start_level : trig_hit;
	assign writing = sample_valid &&
		(state == ST_PRE || state == ST_POST);

	always_comb
	begin
		next_state     = state;
		next_addr      = addr;
		next_pre_cnt   = pre_cnt;
		next_post_cnt  = post_cnt;
		next_trig_addr = trig_addr;
		if (writing)
			next_addr = ADDR_W'(addr + 1'b1);
		if (writing && state == ST_PRE && pre_cnt != pre_count)
			next_pre_cnt = (ADDR_W+1)'(pre_cnt + 1'b1);
		if (writing && state == ST_POST)
			next_post_cnt = (ADDR_W+1)'(post_cnt + 1'b1);
		unique case (state)
			ST_IDLE:
			begin
				if (arm && fit_ok && (gated ? start_level : start_hit))
				begin
					next_state   = ST_PRE;
					next_pre_cnt = COUNT_RESET;
				end
			end
			ST_PRE:
			begin
				if (go_post)
				begin
					next_state     = ST_POST;
					next_post_cnt  = COUNT_RESET;
					next_trig_addr = next_addr;
				end
			end
			ST_POST:
			begin
				if (next_post_cnt >= post_count)
					next_state = ST_DONE;
			end
			ST_DONE:
			begin
				if (!arm)
					next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state     <= ST_IDLE;
			addr      <= ADDR_RESET;
			pre_cnt   <= COUNT_RESET;
			post_cnt  <= COUNT_RESET;
			trig_addr <= ADDR_RESET;
			dig_prev  <= 1'b0;
			ana_prev  <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			addr      <= next_addr;
			pre_cnt   <= next_pre_cnt;
			post_cnt  <= next_post_cnt;
			trig_addr <= next_trig_addr;
			dig_prev  <= dig_in;
			ana_prev  <= sample_valid ? ana_above : ana_prev;
		end
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mem_we     <= 1'b0;
			mem_addr   <= ADDR_RESET;
			mem_data   <= '0;
			done       <= 1'b0;
			config_err <= 1'b0;
			pre_short  <= 1'b0;
			phase      <= ST_IDLE;
		end
		else
		begin
			mem_we     <= writing;
			mem_addr   <= addr;
			mem_data   <= sample;
			done       <= (next_state == ST_DONE);
			config_err <= !fit_ok;
			// trigger came before the full pre count was gathered
			pre_short  <= (state == ST_PRE && next_state == ST_POST) ?
				(pre_cnt != pre_count) : pre_short;
			phase      <= next_state;
		end
	end

	// ****************************************************************
	// decimated stream path
	// ****************************************************************
	logic [DECIM_W-1:0]  dec_cnt;
	logic [DECIM_W-1:0]  next_dec_cnt;
	logic                dec_take;
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic [SAMPLE_W-1:0] fifo_out_data;
	logic                hold_ready;

	// samples are dropped rather than stalling capture when the host lags
	assign dec_take = stream_mode && writing && (dec_cnt == DECIM_RESET);
	assign hold_ready = !stream_valid || stream_ready;

	always_comb
	begin
		next_dec_cnt = dec_cnt;
		if (stream_mode && writing)
			next_dec_cnt = (dec_cnt >= decim) ? DECIM_RESET :
				DECIM_W'(dec_cnt + 1'b1);
	end

	sample_fifo
	#(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	)
	u_fifo
	(
		.clk       (clk),
		.rstn      (rstn),
		.in_data   (sample),
		.in_valid  (dec_take),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (hold_ready)
	);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dec_cnt      <= DECIM_RESET;
			stream_valid <= 1'b0;
			stream_data  <= '0;
		end
		else
		begin
			dec_cnt <= next_dec_cnt;
			if (hold_ready)
			begin
				stream_valid <= fifo_out_valid;
				stream_data  <= fifo_out_data;
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_post_entry;
		state == ST_PRE && go_post;
	endsequence

	chk_idle_hold: assert property (@(posedge clk) disable iff (!rstn)
		state == ST_IDLE && !(arm && fit_ok) |=> state == ST_IDLE)
		else $error("left idle without a start");
	chk_wrap_addr: assert property (@(posedge clk) disable iff (!rstn)
		writing |=> addr == ADDR_W'($past(addr) + 1'b1))
		else $error("write address did not advance");
	chk_fit_block: assert property (@(posedge clk) disable iff (!rstn)
		state == ST_IDLE && !fit_ok |=> state == ST_IDLE)
		else $error("started with oversize counts");
	chk_post_move: assert property (@(posedge clk) disable iff (!rstn)
		s_post_entry |=> state == ST_POST && post_cnt == COUNT_RESET)
		else $error("post phase not entered");
	chk_stream_soft: assert property (@(posedge clk) disable iff (!rstn)
		stream_mode && !gated && state == ST_PRE && !soft_event
		|=> state == ST_PRE)
		else $error("stream mode left pre without host");
	chk_done_flag: assert property (@(posedge clk) disable iff (!rstn)
		state == ST_DONE |-> !writing ##1 (done || !arm))
		else $error("done state without flag");
	chk_stream_dec: assert property (@(posedge clk) disable iff (!rstn)
		dec_take && decim != DECIM_RESET |=> dec_cnt != DECIM_RESET)
		else $error("decimation did not skip a sample");
	chk_edge_sel: assert property (@(posedge clk) disable iff (!rstn)
		state == ST_IDLE && arm && fit_ok && !gated && start_src == SRC_DIGITAL
		&& (dig_in ^ start_falling) && !(dig_prev ^ start_falling)
		|=> state == ST_PRE)
		else $error("digital edge ignored");
endmodule
`default_nettype wire

// ---- verilog/sample_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module sample_fifo
#(
	parameter int WIDTH = 24,
	parameter int DEPTH = 4
)
(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      fill;
	logic [PW-1:0]    next_wr_ptr;
	logic [PW-1:0]    next_rd_ptr;
	logic [PW:0]      next_fill;
	logic             push;
	logic             pop;

	assign in_ready  = (fill != (PW+1)'(DEPTH));
	assign out_valid = (fill != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
		next_fill   = fill;
		if (push && !pop)
			next_fill = (PW+1)'(fill + 1'b1);
		else if (pop && !push)
			next_fill = (PW+1)'(fill - 1'b1);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fill   <= next_fill;
		end
	end

	// storage has no reset; only written entries are ever read
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule
`default_nettype wire
